// file: dps_pkg.sv
// dual synthesizer core: shared constants, carrier types and the dual-modulus feedback divider
package dps_pkg;

  // ***************************************************************
  // serial load word layout
  // ***************************************************************
  localparam int WORD_W       = 24;
  localparam int ADDR_W       = 2;
  localparam int ADDR_LSB     = 0;
  localparam logic [1:0] ADDR_AUX_REF  = 2'h0;
  localparam logic [1:0] ADDR_AUX_FB   = 2'h1;
  localparam logic [1:0] ADDR_MAIN_REF = 2'h2;
  localparam logic [1:0] ADDR_MAIN_FB  = 2'h3;
  localparam logic [23:0] WORD_RESET   = 24'h000000;

  // reference words
  localparam int R_LSB        = 2;
  localparam int R_W          = 15;
  localparam logic [14:0] R_MIN = 15'h0003;
  localparam int SRC_SEL_BIT  = 23;
  localparam int FRAC16_BIT   = 22;
  localparam int AUX_GAIN_BIT = 18;
  localparam int POL_BIT      = 17;
  localparam int DOUBLER_BIT  = 22;
  localparam int MAIN_GAIN_LSB = 18;
  localparam int MAIN_GAIN_W  = 4;

  // feedback words
  localparam int AUX_A_LSB    = 2;
  localparam int AUX_A_W      = 3;
  localparam int AUX_B_LSB    = 5;
  localparam int AUX_B_W      = 12;
  localparam int FRAC_LSB     = 2;
  localparam int FRAC_W       = 4;
  localparam int MAIN_A_LSB   = 6;
  localparam int MAIN_A_W_WIDE   = 5;
  localparam int MAIN_A_W_NARROW = 4;
  localparam int MAIN_B_LSB   = 11;
  localparam int MAIN_B_W     = 10;

  // fractional denominators and pump current steps (units of 100 uA)
  localparam logic [4:0] FRAC_DEN_16 = 5'h10;
  localparam logic [4:0] FRAC_DEN_15 = 5'h0f;
  localparam logic [3:0] AUX_STEPS_LOW  = 4'h1;
  localparam logic [3:0] AUX_STEPS_HIGH = 4'h8;

  // ***************************************************************
  // synchronised pin indices
  // ***************************************************************
  localparam int PIN_N        = 8;
  localparam int PIN_SER_CLK  = 0;
  localparam int PIN_SER_DATA = 1;
  localparam int PIN_LOAD     = 2;
  localparam int PIN_REF_A    = 3;
  localparam int PIN_REF_B    = 4;
  localparam int PIN_MAIN_FB  = 5;
  localparam int PIN_AUX_FB   = 6;
  localparam int PIN_PWRDN    = 7;

  // pump pin: level toward supply when driven, enable low while driving
  typedef struct packed {
    logic toward_supply;
    logic oe_n;
  } dps_pump_t;

endpackage

`timescale 1ns/1ps

// ***************************************************************
// dual-modulus swallow/main counter chain
// ***************************************************************
module dps_modulus_divider import dps_pkg::*; #(
  parameter int AW = 5,
  parameter int BW = 10
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          tick,
  input  wire logic [AW-1:0] a_val,
  input  wire logic [BW-1:0] b_val,
  input  wire logic          extra,
  output logic               mod_ctrl,
  output logic               done
);

  typedef struct packed {
    logic [AW:0]   a_cnt;
    logic [BW-1:0] b_cnt;
    logic          mod;
    logic          done;
  } dps_div_state_t;

  dps_div_state_t s_q;
  dps_div_state_t s_d;

  // each tick is one prescaler output cycle; mod high asks for the long modulus
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (tick) begin
      if (s_q.b_cnt <= BW'(1)) begin
        // an extra swallow lengthens this period by one oscillator cycle
        s_d.a_cnt = {1'b0, a_val} + (AW+1)'(extra);
        s_d.b_cnt = b_val;
        s_d.done  = 1'b1;
        s_d.mod   = (s_d.a_cnt != '0);
      end else begin
        s_d.b_cnt = s_q.b_cnt - BW'(1);
        if (s_q.a_cnt != '0) begin
          s_d.a_cnt = s_q.a_cnt - (AW+1)'(1);
        end
        s_d.mod = (s_d.a_cnt != '0);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign mod_ctrl = s_q.mod;
  assign done     = s_q.done;

endmodule

// file: dps_core.sv
// dual synthesizer digital core: serial load, dividers, accumulator, detectors, pumps

`timescale 1ns/1ps

module dps_core import dps_pkg::*; #(
  parameter bit WIDE_VARIANT = 1'b1
) (
  input  wire logic SYS_CLK,
  input  wire logic RESET_N,
  input  wire logic SER_CLK,
  input  wire logic SER_DATA,
  input  wire logic LOAD_STROBE,
  input  wire logic REF_INPUT_A,
  input  wire logic REF_INPUT_B,
  input  wire logic MAIN_FEEDBACK_INPUT,
  input  wire logic AUX_FEEDBACK_INPUT,
  input  wire logic POWER_DOWN_REQ,
  output dps_pump_t MAIN_PUMP_OUTPUT,
  output dps_pump_t AUX_PUMP_OUTPUT,
  output logic [4:0] MAIN_PUMP_STEPS,
  output logic [3:0] AUX_PUMP_STEPS,
  output logic      MAIN_MODULUS_CTRL,
  output logic      AUX_MODULUS_CTRL,
  output logic      FRAC_OVERFLOW,
  output logic      MAIN_RATIO_BAD,
  output logic      AUX_RATIO_BAD,
  output logic      SUPPLY_DOUBLER_ENABLE,
  output logic      DOUBLER_DRIVE,
  output logic      SHUTDOWN_DONE
);

  localparam int MAIN_AW = WIDE_VARIANT ? MAIN_A_W_WIDE : MAIN_A_W_NARROW;

  // timing overview, in system clock edges:
  //   every pin passes sync1 and sync2; sync3 is the edge reference and also the
  //   sampled level for serial data, doubler drive and shutdown, so a pin edge is
  //   acted on three edges after it lands
  //   a load strobe edge writes its latch on the third edge, and the derived
  //   outputs (steps, doubler, ratio flags) follow one edge later
  //   reference and prescaler edges are counted at the same latency
  // limitations:
  //   a pin level shorter than about one system clock may be missed, so the
  //   reference and prescaler inputs must run well below half the system clock
  //   the prescaler modulus itself lives outside; this core only asks for the
  //   long modulus through the modulus control outputs
  //   ratios below the reference minimum are held silent instead of divided,
  //   which keeps the detector from seeing a runaway reference
  //   no power-down counter reset is kept; shutdown only reports readiness

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic [PIN_N-1:0]     sync1;
    logic [PIN_N-1:0]     sync2;
    logic [PIN_N-1:0]     sync3;
    logic [WORD_W-1:0]    shift;
    logic [WORD_W-1:0]    w_aux_ref;
    logic [WORD_W-1:0]    w_aux_fb;
    logic [WORD_W-1:0]    w_main_ref;
    logic [WORD_W-1:0]    w_main_fb;
    logic [1:0][R_W-1:0]  r_cnt;       // index 0 aux, 1 main
    logic [1:0]           r_pulse;
    logic [1:0]           ref_seen;
    logic [1:0]           fb_seen;
    logic [FRAC_W-1:0]    acc;
    logic                 ovf;
    dps_pump_t            main_pump;
    dps_pump_t            aux_pump;
    logic [4:0]           main_steps;
    logic [3:0]           aux_steps;
    logic                 main_bad;
    logic                 aux_bad;
    logic                 dbl_en;
    logic                 dbl_drive;
    logic                 shut_done;
  } dps_core_state_t;

  dps_core_state_t s_q;
  dps_core_state_t s_d;

  logic [PIN_N-1:0] pins;
  logic [PIN_N-1:0] rise;
  logic             main_mod;
  logic             aux_mod;
  logic             main_done;
  logic             aux_done;
  logic [4:0]       frac_sum;
  logic [4:0]       frac_den;
  logic             frac_wrap;
  logic [1:0]       r_tick;
  logic [1:0][R_W-1:0] r_val;
  logic [1:0]       fb_pulse;
  logic [1:0]       pol;

  assign pins = {POWER_DOWN_REQ, AUX_FEEDBACK_INPUT, MAIN_FEEDBACK_INPUT, REF_INPUT_B,
                 REF_INPUT_A, LOAD_STROBE, SER_DATA, SER_CLK};

  // edges look at the second and third stages only, never the first
  assign rise = s_q.sync2 & ~s_q.sync3;

  // ***************************************************************
  // fractional accumulator terms
  // ***************************************************************
  // denominator choice comes from the aux reference word
  assign frac_den  = s_q.w_aux_ref[FRAC16_BIT] ? FRAC_DEN_16 : FRAC_DEN_15;
  assign frac_sum  = {1'b0, s_q.acc} + {1'b0, s_q.w_main_fb[FRAC_LSB +: FRAC_W]};
  assign frac_wrap = (frac_sum >= frac_den);

  // ***************************************************************
  // reference clock routing
  // ***************************************************************
  // common path: input a feeds both; separate: a feeds aux, b feeds main
  assign r_tick[0] = rise[PIN_REF_A];
  assign r_tick[1] = s_q.w_aux_ref[SRC_SEL_BIT] ? rise[PIN_REF_A]
                                                : rise[PIN_REF_B];
  assign r_val[0]  = s_q.w_aux_ref[R_LSB +: R_W];
  assign r_val[1]  = s_q.w_main_ref[R_LSB +: R_W];
  assign fb_pulse  = {main_done, aux_done};
  assign pol       = {s_q.w_main_ref[POL_BIT], s_q.w_aux_ref[POL_BIT]};

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    s_d         = s_q;
    s_d.sync1   = pins;
    s_d.sync2   = s_q.sync1;
    s_d.sync3   = s_q.sync2;

    // serial shift, msb first: the address lands in the two low bits last
    if (rise[PIN_SER_CLK]) begin
      s_d.shift = {s_q.shift[WORD_W-2:0], s_q.sync3[PIN_SER_DATA]};
    end

    // only the strobe edge touches a latch; clocking alone changes nothing
    if (rise[PIN_LOAD]) begin
      unique case (s_q.shift[ADDR_LSB +: ADDR_W])
        ADDR_AUX_REF:  s_d.w_aux_ref  = s_q.shift;
        ADDR_AUX_FB:   s_d.w_aux_fb   = s_q.shift;
        ADDR_MAIN_REF: s_d.w_main_ref = s_q.shift;
        ADDR_MAIN_FB:  s_d.w_main_fb  = s_q.shift;
      endcase
    end

    // reference dividers; ratios under the minimum are held silent
    for (int i = 0; i < 2; i++) begin
      s_d.r_pulse[i] = 1'b0;
      if (r_tick[i]) begin
        if (s_q.r_cnt[i] <= R_W'(1)) begin
          s_d.r_cnt[i]   = r_val[i];
          s_d.r_pulse[i] = (r_val[i] >= R_MIN);
        end else begin
          s_d.r_cnt[i] = s_q.r_cnt[i] - R_W'(1);
        end
      end
    end

    // accumulator steps once per main comparison period
    s_d.ovf = 1'b0;
    if (main_done) begin
      s_d.acc = frac_wrap ? 4'(frac_sum - frac_den) : frac_sum[FRAC_W-1:0];
      s_d.ovf = frac_wrap;
    end

    // a detector pulse is latched until its partner arrives; the pump then stays
    // driven while one side leads, and returns to high impedance once both are in
    // trade-off: no anti-dead-zone pulse, so an exactly aligned loop never drives
    // phase detectors: whichever edge came first waits; both seen clears both
    for (int i = 0; i < 2; i++) begin
      s_d.ref_seen[i] = s_q.ref_seen[i] | s_q.r_pulse[i];
      s_d.fb_seen[i]  = s_q.fb_seen[i] | fb_pulse[i];
      if (s_d.ref_seen[i] && s_d.fb_seen[i]) begin
        s_d.ref_seen[i] = 1'b0;
        s_d.fb_seen[i]  = 1'b0;
      end
    end

    // pump pins: a reference lead pumps up for positive polarity, down otherwise
    s_d.main_pump.oe_n          = ~(s_q.ref_seen[1] | s_q.fb_seen[1]);
    s_d.main_pump.toward_supply = pol[1] ? s_q.ref_seen[1] : s_q.fb_seen[1];
    s_d.aux_pump.oe_n           = ~(s_q.ref_seen[0] | s_q.fb_seen[0]);
    s_d.aux_pump.toward_supply  = pol[0] ? s_q.ref_seen[0] : s_q.fb_seen[0];

    // current magnitudes in units of 100 uA
    s_d.main_steps = {1'b0, s_q.w_main_ref[MAIN_GAIN_LSB +: MAIN_GAIN_W]} + 5'h01;
    s_d.aux_steps  = s_q.w_aux_ref[AUX_GAIN_BIT] ? AUX_STEPS_HIGH : AUX_STEPS_LOW;

    // the continuous range needs main count not below swallow count
    s_d.main_bad = (MAIN_B_W'(s_q.w_main_fb[MAIN_A_LSB +: MAIN_AW])
                    > s_q.w_main_fb[MAIN_B_LSB +: MAIN_B_W]);
    s_d.aux_bad  = (AUX_B_W'(s_q.w_aux_fb[AUX_A_LSB +: AUX_A_W])
                    > s_q.w_aux_fb[AUX_B_LSB +: AUX_B_W]);

    // doubler: switching follows input b while enabled, and blocks shutdown
    s_d.dbl_en    = s_q.w_main_ref[DOUBLER_BIT];
    s_d.dbl_drive = s_q.w_main_ref[DOUBLER_BIT] & s_q.sync3[PIN_REF_B];
    s_d.shut_done = s_q.sync3[PIN_PWRDN] & ~s_q.w_main_ref[DOUBLER_BIT];
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  // pumps reset to high impedance, all control words to zero
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      s_q                    <= '0;
      s_q.w_aux_ref          <= WORD_RESET;
      s_q.w_aux_fb           <= WORD_RESET;
      s_q.w_main_ref         <= WORD_RESET;
      s_q.w_main_fb          <= WORD_RESET;
      s_q.main_pump.oe_n     <= 1'b1;
      s_q.aux_pump.oe_n      <= 1'b1;
      s_q.main_steps         <= 5'h01;
      s_q.aux_steps          <= AUX_STEPS_LOW;
    end else begin
      s_q <= s_d;
    end
  end

  // ***************************************************************
  // feedback dividers
  // ***************************************************************
  // both chains share one counter module; the swallow count sets how many
  // prescaler cycles at the start of a period ask for the long modulus, and the
  // main count sets the period length in prescaler cycles
  // the main chain takes the accumulator wrap as one extra swallow, so that an
  // overflow stretches that period by exactly one oscillator cycle
  // main chain: prescaler pulses counted, overflow adds one swallow
  dps_modulus_divider #(
    .AW (MAIN_AW),
    .BW (MAIN_B_W)
  ) u_main_div (
    .clk      (SYS_CLK),
    .rst_n    (RESET_N),
    .tick     (rise[PIN_MAIN_FB]),
    .a_val    (s_q.w_main_fb[MAIN_A_LSB +: MAIN_AW]),
    .b_val    (s_q.w_main_fb[MAIN_B_LSB +: MAIN_B_W]),
    .extra    (frac_wrap),
    .mod_ctrl (main_mod),
    .done     (main_done)
  );

  // aux chain: fixed 8/9 prescaler outside, integer only
  dps_modulus_divider #(
    .AW (AUX_A_W),
    .BW (AUX_B_W)
  ) u_aux_div (
    .clk      (SYS_CLK),
    .rst_n    (RESET_N),
    .tick     (rise[PIN_AUX_FB]),
    .a_val    (s_q.w_aux_fb[AUX_A_LSB +: AUX_A_W]),
    .b_val    (s_q.w_aux_fb[AUX_B_LSB +: AUX_B_W]),
    .extra    (1'b0),
    .mod_ctrl (aux_mod),
    .done     (aux_done)
  );

  // ***************************************************************
  // outputs, all from flip-flops
  // ***************************************************************
  // the modulus controls come straight from the divider flip-flops above, so
  // every output here is a register with no logic after it
  assign MAIN_PUMP_OUTPUT      = s_q.main_pump;
  assign AUX_PUMP_OUTPUT       = s_q.aux_pump;
  assign MAIN_PUMP_STEPS       = s_q.main_steps;
  assign AUX_PUMP_STEPS        = s_q.aux_steps;
  assign MAIN_MODULUS_CTRL     = main_mod;
  assign AUX_MODULUS_CTRL      = aux_mod;
  assign FRAC_OVERFLOW         = s_q.ovf;
  assign MAIN_RATIO_BAD        = s_q.main_bad;
  assign AUX_RATIO_BAD         = s_q.aux_bad;
  assign SUPPLY_DOUBLER_ENABLE = s_q.dbl_en;
  assign DOUBLER_DRIVE         = s_q.dbl_drive;
  assign SHUTDOWN_DONE         = s_q.shut_done;

endmodule

// file: dps_core_assertions.sv
// concurrent checks on the ports of the dual synthesizer core
`timescale 1ns/1ps
module dps_core_assertions import dps_pkg::*; (
  input wire logic       SYS_CLK,
  input wire logic       RESET_N,
  input wire logic       LOAD_STROBE,
  input wire logic       MAIN_FEEDBACK_INPUT,
  input wire logic       AUX_FEEDBACK_INPUT,
  input wire dps_pump_t  MAIN_PUMP_OUTPUT,
  input wire logic [4:0] MAIN_PUMP_STEPS,
  input wire logic [3:0] AUX_PUMP_STEPS,
  input wire logic       MAIN_MODULUS_CTRL,
  input wire logic       AUX_MODULUS_CTRL,
  input wire logic       FRAC_OVERFLOW,
  input wire logic       SUPPLY_DOUBLER_ENABLE,
  input wire logic       DOUBLER_DRIVE,
  input wire logic       SHUTDOWN_DONE
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);
  // ****************************************
  // port relations
  // ****************************************
  a_aux_steps_pair: assert property (AUX_PUMP_STEPS == 4'h1 || AUX_PUMP_STEPS == 4'h8)
    else $error("aux pump steps not 1 or 8");
  a_main_steps_range: assert property (MAIN_PUMP_STEPS inside {[5'h01:5'h10]})
    else $error("main pump steps out of range");
  // six quiet strobe samples cover the three-edge latch path plus the derived register
  a_load_hold_words: assert property (!LOAD_STROBE [*6] |-> $stable(MAIN_PUMP_STEPS)
    && $stable(AUX_PUMP_STEPS) && $stable(SUPPLY_DOUBLER_ENABLE))
    else $error("control outputs moved without a load strobe");
  a_drive_gated: assert property (DOUBLER_DRIVE |-> SUPPLY_DOUBLER_ENABLE
    || $past(SUPPLY_DOUBLER_ENABLE))
    else $error("doubler drive while doubler disabled");
  a_shutdown_held: assert property (SHUTDOWN_DONE |-> !SUPPLY_DOUBLER_ENABLE
    || !$past(SUPPLY_DOUBLER_ENABLE))
    else $error("shutdown completed with doubler enabled");
  a_ovf_single_cycle: assert property (FRAC_OVERFLOW |=> !FRAC_OVERFLOW)
    else $error("overflow pulse longer than one cycle");
  // modulus control may only move on prescaler edges
  a_main_mod_idle: assert property ($stable(MAIN_FEEDBACK_INPUT) [*6]
    |-> $stable(MAIN_MODULUS_CTRL))
    else $error("main modulus control moved without prescaler edge");
  a_aux_mod_idle: assert property ($stable(AUX_FEEDBACK_INPUT) [*6]
    |-> $stable(AUX_MODULUS_CTRL))
    else $error("aux modulus control moved without prescaler edge");
  c_overflow: cover property (FRAC_OVERFLOW);
  c_main_pump: cover property (!MAIN_PUMP_OUTPUT.oe_n);
  c_shutdown: cover property (SHUTDOWN_DONE);
endmodule

bind dps_core dps_core_assertions i_chk (
  .SYS_CLK(SYS_CLK),
  .RESET_N(RESET_N),
  .LOAD_STROBE(LOAD_STROBE),
  .MAIN_FEEDBACK_INPUT(MAIN_FEEDBACK_INPUT),
  .AUX_FEEDBACK_INPUT(AUX_FEEDBACK_INPUT),
  .MAIN_PUMP_OUTPUT(MAIN_PUMP_OUTPUT),
  .MAIN_PUMP_STEPS(MAIN_PUMP_STEPS),
  .AUX_PUMP_STEPS(AUX_PUMP_STEPS),
  .MAIN_MODULUS_CTRL(MAIN_MODULUS_CTRL),
  .AUX_MODULUS_CTRL(AUX_MODULUS_CTRL),
  .FRAC_OVERFLOW(FRAC_OVERFLOW),
  .SUPPLY_DOUBLER_ENABLE(SUPPLY_DOUBLER_ENABLE),
  .DOUBLER_DRIVE(DOUBLER_DRIVE),
  .SHUTDOWN_DONE(SHUTDOWN_DONE)
);

// file: dps_host_model.sv
// host side model driving the three-wire serial load port
`timescale 1ns/1ps
module dps_host_model (
  input  wire logic clk,
  output logic      ser_clk,
  output logic      ser_data,
  output logic      load_strobe
);
  initial begin
    ser_clk = 1'b0;
    ser_data = 1'b0;
    load_strobe = 1'b0;
  end
  // ****************************************
  // serial word transfer
  // ****************************************
  // every level is held four clocks, so the device synchronisers never miss one
  task automatic send(input logic [23:0] word, input logic strobe);
    for (int i = 23; i >= 0; i--) begin
      ser_data <= word[i];
      repeat (4) @(posedge clk);
      ser_clk <= 1'b1;
      repeat (4) @(posedge clk);
      ser_clk <= 1'b0;
    end
    ser_data <= ~word[0]; // released line must not keep the last bit
    repeat (4) @(posedge clk);
    if (strobe) begin
      load_strobe <= 1'b1;
      repeat (4) @(posedge clk);
      load_strobe <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule

// file: dps_core_test.sv
// self-checking bench for the dual synthesizer core
`timescale 1ns/1ps
module dps_core_test;
  import dps_pkg::*;
  logic        sys_clk, reset_n, pwr_req, ser_clk, ser_data, load_strobe, main_mod_q, aux_mod_q;
  logic [3:0]  pins;
  dps_pump_t   main_pump, aux_pump;
  logic [4:0]  main_steps;
  logic [3:0]  aux_steps;
  logic        main_mod, aux_mod, frac_ovf, main_bad, aux_bad, dbl_en, dbl_drive, shut_done;
  logic [15:0] lfsr;
  logic [23:0] rw;
  int          n_errors, checks, n_rise, n_ovf, dbl_seen, expv, f16, num, n_aux_rise;
  int unsigned model_word [4];

  dps_host_model i_host (.clk(sys_clk), .ser_clk(ser_clk), .ser_data(ser_data),
    .load_strobe(load_strobe));
  dps_core i_dut (.SYS_CLK(sys_clk), .RESET_N(reset_n), .SER_CLK(ser_clk),
    .SER_DATA(ser_data), .LOAD_STROBE(load_strobe), .REF_INPUT_A(pins[0]),
    .REF_INPUT_B(pins[1]), .MAIN_FEEDBACK_INPUT(pins[2]), .AUX_FEEDBACK_INPUT(pins[3]),
    .POWER_DOWN_REQ(pwr_req), .MAIN_PUMP_OUTPUT(main_pump), .AUX_PUMP_OUTPUT(aux_pump),
    .MAIN_PUMP_STEPS(main_steps), .AUX_PUMP_STEPS(aux_steps), .MAIN_MODULUS_CTRL(main_mod),
    .AUX_MODULUS_CTRL(aux_mod), .FRAC_OVERFLOW(frac_ovf), .MAIN_RATIO_BAD(main_bad),
    .AUX_RATIO_BAD(aux_bad), .SUPPLY_DOUBLER_ENABLE(dbl_en), .DOUBLER_DRIVE(dbl_drive),
    .SHUTDOWN_DONE(shut_done));

  // ****************************************
  // clock, monitors and helpers
  // ****************************************
  always #5 sys_clk = ~sys_clk;
  // period starts are counted from modulus control rises
  always @(posedge sys_clk) begin
    main_mod_q <= main_mod;
    aux_mod_q <= aux_mod;
    if (main_mod && !main_mod_q) n_rise++;
    if (aux_mod && !aux_mod_q) n_aux_rise++;
    if (frac_ovf) n_ovf++;
    if (dbl_drive) dbl_seen++;
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {1'b0, s[15:1]} ^ (s[0] ? 16'hb400 : 16'h0000);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // expected outputs come from the model of the four latches
  task automatic chk_words();
    chk(main_steps, ((model_word[2] >> MAIN_GAIN_LSB) & 15) + 1);
    chk(aux_steps, model_word[0][AUX_GAIN_BIT] ? 8 : 1);
    chk(dbl_en, model_word[2][DOUBLER_BIT]);
    chk(main_bad, ((model_word[3] >> MAIN_A_LSB) & 31) > (model_word[3] >> MAIN_B_LSB & 1023));
    chk(aux_bad, ((model_word[1] >> AUX_A_LSB) & 7) > ((model_word[1] >> AUX_B_LSB) & 4095));
  endtask
  task automatic write(input int unsigned w, input logic strobe);
    i_host.send(w[23:0], strobe);
    if (strobe) model_word[w & 3] = w & 24'hffffff;
    chk_words();
  endtask
  // toggles one pin; four clocks per level keeps every edge visible
  task automatic toggle(input int which, input int n);
    repeat (2 * n) begin
      pins[which] <= ~pins[which];
      repeat (4) @(posedge sys_clk);
    end
  endtask
  task automatic test_done();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #500000;
    n_errors++;
    test_done();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    reset_n = 1'b0;
    pwr_req = 1'b0;
    pins = 4'h0;
    main_mod_q = 1'b0;
    aux_mod_q = 1'b0;
    lfsr = 16'h003b;
    model_word = '{default: 0};
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    chk_words();
    chk({main_pump.oe_n, aux_pump.oe_n}, 2'h3);
    // random words to every address, one of them shifted without a strobe
    for (int k = 0; k < 8; k++) begin
      lfsr = lfsr_next(lfsr);
      rw[15:0] = lfsr;
      lfsr = lfsr_next(lfsr);
      rw[23:16] = lfsr[7:0];
      write({8'h00, rw[23:2], k[1:0]}, k != 3);
    end
    // separate inputs: input a clocks only the aux reference divider, ref leads, pump follows polarity
    write((7 << 5) | (1 << 2) | 1, 1'b1);
    for (int p = 0; p < 2; p++) begin
      write((p << 17) | (3 << 2), 1'b1);
      write((p << 17) | (3 << 2) | 2, 1'b1);
      toggle(0, 8);
      chk(aux_pump, {p[0], 1'b0});
      chk(main_pump.oe_n, 1'b1);
    end
    // common input: input a now clocks the main reference divider too
    write((1 << 23) | (3 << 2), 1'b1);
    toggle(0, 8);
    chk(main_pump, 2'h2);
    // aux chain swallow 1, main 7: 16 prescaler edges start three periods
    n_aux_rise = 0;
    toggle(3, 16);
    chk(n_aux_rise, 3);
    // doubler drive and shutdown interlock
    pwr_req <= 1'b1;
    write((1 << 22) | (5 << 18) | (3 << 2) | 2, 1'b1);
    dbl_seen = 0;
    toggle(1, 4);
    chk(dbl_seen > 0, 1'b1);
    chk(shut_done, 1'b0);
    write((3 << 2) | 2, 1'b1);
    dbl_seen = 0;
    toggle(1, 4);
    chk(dbl_seen, 0);
    chk(shut_done, 1'b1);
    pwr_req <= 1'b0;
    // fractional overflow count over 48 periods of 8 prescaler edges, swallow of 2
    for (int c = 0; c < 3; c++) begin
      f16 = (c > 0);
      num = (c < 2) ? 15 : 0;
      write((f16 << 22) | (3 << 2), 1'b1);
      write((8 << 11) | (2 << 6) | (num << 2) | 3, 1'b1);
      n_rise = 0;
      n_ovf = 0;
      toggle(2, 8 * 48);
      expv = n_rise * num / (f16 ? 16 : 15);
      chk(n_rise >= 46 && n_rise <= 49, 1'b1);
      chk(n_ovf >= expv - 1 && n_ovf <= expv + 1, 1'b1);
    end
    test_done();
  end
endmodule
